// ---- verilog/dcba_pkg.sv ----
// Constants and types shared by the dual-processor bus arbiter.
// Assumes a single core clock; widths are in bits, WAIT_CYCLES in core clock cycles, clock rates in MHz.
`default_nettype none

package dcba_pkg;
    // -------------------------------------------------------------------
    // Widths
    // -------------------------------------------------------------------
    localparam int unsigned FULL_AW   = 20;
    localparam int unsigned SHORT_AW  = 16;
    localparam int unsigned BANK_W    = 4;
    localparam int unsigned MAIN_DW   = 8;
    localparam int unsigned EXP_DW    = 16;
    localparam int unsigned EXP_DMA_N = 4;
    localparam int unsigned EXP_IRQ_N = 7;

    // -------------------------------------------------------------------
    // Reset values and fixed codes
    // -------------------------------------------------------------------
    localparam logic [BANK_W-1:0]   BANK_RST       = 4'h0;
    localparam logic [SHORT_AW-1:0] HANDOVER_PORT  = 16'h00C0;
    localparam logic [7:0]          SLOW_IO_PAGE   = 8'h00;
    localparam logic [7:0]          SLOW_IO_MASK   = 8'hFF;
    localparam logic                BANK_TGT_CPU8  = 1'b0;
    localparam logic                BANK_TGT_DMA   = 1'b1;

    // -------------------------------------------------------------------
    // Timing
    // -------------------------------------------------------------------
    localparam int unsigned XTAL_MHZ   = 24;
    localparam int unsigned CPU16_MHZ  = 8;
    localparam int unsigned CPU8_MHZ   = 6;
    localparam int unsigned DMA_MHZ    = 4;
    localparam int unsigned WAIT_CYCLES = 8;
    localparam int unsigned DIV_W      = 3;
    // Crystal half-periods per output half-period
    localparam logic [DIV_W-1:0] HALF_CPU16 = DIV_W'(XTAL_MHZ / CPU16_MHZ);
    localparam logic [DIV_W-1:0] HALF_CPU8  = DIV_W'(XTAL_MHZ / CPU8_MHZ);
    localparam logic [DIV_W-1:0] HALF_DMA   = DIV_W'(XTAL_MHZ / DMA_MHZ);

    typedef enum logic [1:0] {
        OWN_CPU16,
        OWN_CPU8,
        OWN_DMA
    } dcba_owner_t;
endpackage : dcba_pkg

`default_nettype wire

// ---- verilog/dcba_arbiter.sv ----
// Main-board bus arbiter, control merge, bank extension and clock logic.
// Assumes all pin inputs are asynchronous; bank loads come from core logic.
`default_nettype none

module dcba_arbiter #(
    parameter int unsigned WAIT_N = dcba_pkg::WAIT_CYCLES
) (
    input  wire logic                               core_clk_in,
    input  wire logic                               sys_rst_in,
    input  wire logic                               xtal_ref_in,
    input  wire logic                               dma_hold_req_in,
    input  wire logic [dcba_pkg::EXP_DMA_N-1:0]     exp_dma_req_in,
    input  wire logic                               int_req_in,
    input  wire logic [dcba_pkg::EXP_IRQ_N-1:0]     exp_irq_in,
    input  wire logic                               cpu16_rd_in,
    input  wire logic                               cpu16_wr_in,
    input  wire logic                               cpu16_io_in,
    input  wire logic [dcba_pkg::FULL_AW-1:0]       cpu16_addr_in,
    input  wire logic                               cpu8_rd_in,
    input  wire logic                               cpu8_wr_in,
    input  wire logic                               cpu8_io_in,
    input  wire logic [dcba_pkg::SHORT_AW-1:0]      cpu8_addr_in,
    input  wire logic                               dma_rd_in,
    input  wire logic                               dma_wr_in,
    input  wire logic                               dma_io_in,
    input  wire logic [dcba_pkg::SHORT_AW-1:0]      dma_addr_in,
    input  wire logic [dcba_pkg::MAIN_DW-1:0]       main_data_in,
    input  wire logic [dcba_pkg::EXP_DW-1:0]        exp_data_in,
    input  wire logic                               bank_load_in,
    input  wire logic                               bank_target_in,
    input  wire logic [dcba_pkg::BANK_W-1:0]        bank_value_in,
    output logic                                    grant_cpu16_out,
    output logic                                    grant_cpu8_out,
    output logic                                    dma_hold_ack_out,
    output logic [dcba_pkg::EXP_DMA_N-1:0]          exp_dma_ack_out,
    output logic                                    offboard_owner_out,
    output logic                                    cpu16_irq_out,
    output logic [dcba_pkg::FULL_AW-1:0]            bus_addr_out,
    output logic                                    bus_rd_out,
    output logic                                    bus_wr_out,
    output logic                                    bus_io_out,
    output logic                                    early_memory_cycle_start_out,
    output logic                                    io_refused_out,
    output logic                                    ready_out,
    output logic [dcba_pkg::MAIN_DW-1:0]            main_data_out,
    output logic [dcba_pkg::EXP_DW-1:0]             exp_data_out,
    output logic                                    clk_cpu16_out,
    output logic                                    clk_cpu8_out,
    output logic                                    clk_dma_out
);
    // -------------------------------------------------------------------
    // Pin synchronisers
    // -------------------------------------------------------------------
    localparam int unsigned SW = 1 + 1 + dcba_pkg::EXP_DMA_N + 1 + dcba_pkg::EXP_IRQ_N + 9
                               + dcba_pkg::FULL_AW + 2 * dcba_pkg::SHORT_AW
                               + dcba_pkg::MAIN_DW + dcba_pkg::EXP_DW;

    logic [SW-1:0] sync1_q;
    logic [SW-1:0] sync2_q;
    wire  [SW-1:0] pin_raw = {xtal_ref_in, dma_hold_req_in, exp_dma_req_in, int_req_in, exp_irq_in,
                              cpu16_rd_in, cpu16_wr_in, cpu16_io_in,
                              cpu8_rd_in, cpu8_wr_in, cpu8_io_in,
                              dma_rd_in, dma_wr_in, dma_io_in,
                              cpu16_addr_in, cpu8_addr_in, dma_addr_in,
                              main_data_in, exp_data_in};

    always_ff @(posedge core_clk_in) begin
        sync1_q <= pin_raw;
        sync2_q <= sync1_q;
    end

    wire                                   x_s;
    wire                                   hold_s;
    wire [dcba_pkg::EXP_DMA_N-1:0]         xreq_s;
    wire                                   irq_s;
    wire [dcba_pkg::EXP_IRQ_N-1:0]         xirq_s;
    wire                                   c16_rd, c16_wr, c16_io;
    wire                                   c8_rd, c8_wr, c8_io;
    wire                                   d_rd, d_wr, d_io;
    wire [dcba_pkg::FULL_AW-1:0]           c16_a;
    wire [dcba_pkg::SHORT_AW-1:0]          c8_a;
    wire [dcba_pkg::SHORT_AW-1:0]          d_a;
    wire [dcba_pkg::MAIN_DW-1:0]           mdat_s;
    wire [dcba_pkg::EXP_DW-1:0]            xdat_s;

    assign {x_s, hold_s, xreq_s, irq_s, xirq_s, c16_rd, c16_wr, c16_io, c8_rd, c8_wr, c8_io,
            d_rd, d_wr, d_io, c16_a, c8_a, d_a, mdat_s, xdat_s} = sync2_q;

    // -------------------------------------------------------------------
    // Derived clocks
    // -------------------------------------------------------------------
    logic x_prev_q;
    wire  x_edge = x_s ^ x_prev_q;
    logic [2:0] clk_q;
    localparam logic [dcba_pkg::DIV_W-1:0] HALF [3] = '{dcba_pkg::HALF_CPU16,
                                                       dcba_pkg::HALF_CPU8,
                                                       dcba_pkg::HALF_DMA};

    always_ff @(posedge core_clk_in) begin
        x_prev_q <= x_s;
    end

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_div
            logic [dcba_pkg::DIV_W-1:0] cnt_q;
            wire                         wrap = x_edge && (cnt_q == HALF[gi] - 1'b1);
            always_ff @(posedge core_clk_in) begin
                if (sys_rst_in) begin
                    cnt_q      <= '0;
                    clk_q[gi]  <= 1'b0;
                end else if (x_edge) begin
                    cnt_q      <= wrap ? '0 : cnt_q + 1'b1;
                    clk_q[gi]  <= clk_q[gi] ^ wrap;
                end
            end
        end
    endgenerate

    assign clk_cpu16_out = clk_q[0];
    assign clk_cpu8_out  = clk_q[1];
    assign clk_dma_out   = clk_q[2];

    // -------------------------------------------------------------------
    // Bank registers
    // -------------------------------------------------------------------
    logic [dcba_pkg::BANK_W-1:0] bank_cpu8_q;
    logic [dcba_pkg::BANK_W-1:0] bank_dma_q;

    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            bank_cpu8_q <= dcba_pkg::BANK_RST;
            bank_dma_q  <= dcba_pkg::BANK_RST;
        end else if (bank_load_in) begin
            if (bank_target_in == dcba_pkg::BANK_TGT_CPU8) begin
                bank_cpu8_q <= bank_value_in;
            end else begin
                bank_dma_q  <= bank_value_in;
            end
        end
    end

    // -------------------------------------------------------------------
    // Ownership
    // -------------------------------------------------------------------
    dcba_pkg::dcba_owner_t owner_q, owner_d, prev_q;
    logic                            off_q;
    logic [dcba_pkg::EXP_DMA_N-1:0]  chan_q;
    logic                            ho_pend_q;

    wire c16_cyc = c16_rd | c16_wr;
    wire c8_cyc  = c8_rd | c8_wr;
    wire d_cyc   = d_rd | d_wr;
    wire any_irq = irq_s | (|xirq_s);
    wire dma_req = hold_s | (|xreq_s);
    // Lowest expansion channel wins
    wire [dcba_pkg::EXP_DMA_N-1:0] xpick = xreq_s & (~xreq_s + 1'b1);
    wire src_live = off_q ? |(xreq_s & chan_q) : hold_s;
    wire own_cyc  = (owner_q == dcba_pkg::OWN_CPU16) ? c16_cyc :
                    (owner_q == dcba_pkg::OWN_CPU8)  ? c8_cyc : d_cyc;
    wire bus_idle = ~own_cyc & ~bus_rd_out & ~bus_wr_out;
    wire c8_io_hit = (owner_q == dcba_pkg::OWN_CPU8) && c8_cyc && c8_io;
    wire ho_hit   = (owner_q == dcba_pkg::OWN_CPU16) && c16_cyc && c16_io
                    && (c16_a[dcba_pkg::SHORT_AW-1:0] == dcba_pkg::HANDOVER_PORT);

    always_comb begin
        owner_d = owner_q;
        case (owner_q)
            dcba_pkg::OWN_CPU16: begin
                if (dma_req && bus_idle) begin
                    owner_d = dcba_pkg::OWN_DMA;
                end else if (ho_pend_q && bus_idle) begin
                    owner_d = dcba_pkg::OWN_CPU8;
                end
            end
            dcba_pkg::OWN_CPU8: begin
                if (c8_io_hit) begin
                    owner_d = dcba_pkg::OWN_CPU16;
                end else if (dma_req && bus_idle) begin
                    owner_d = dcba_pkg::OWN_DMA;
                end else if (any_irq && bus_idle) begin
                    owner_d = dcba_pkg::OWN_CPU16;
                end
            end
            dcba_pkg::OWN_DMA: begin
                if (!src_live && bus_idle) begin
                    owner_d = prev_q;
                end
            end
            default: begin
                owner_d = dcba_pkg::OWN_CPU16;
            end
        endcase
    end

    wire enter_dma = (owner_d == dcba_pkg::OWN_DMA) && (owner_q != dcba_pkg::OWN_DMA);

    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            owner_q   <= dcba_pkg::OWN_CPU16;
            prev_q    <= dcba_pkg::OWN_CPU16;
            off_q     <= 1'b0;
            chan_q    <= '0;
            ho_pend_q <= 1'b0;
        end else begin
            owner_q   <= owner_d;
            ho_pend_q <= (owner_d == dcba_pkg::OWN_CPU16) && (ho_hit || ho_pend_q);
            if (enter_dma) begin
                prev_q <= owner_q;
                off_q  <= ~hold_s;
                chan_q <= hold_s ? '0 : xpick;
            end
        end
    end

    wire is_dma = (owner_q == dcba_pkg::OWN_DMA);
    assign grant_cpu16_out    = (owner_q == dcba_pkg::OWN_CPU16);
    assign grant_cpu8_out     = (owner_q == dcba_pkg::OWN_CPU8);
    assign dma_hold_ack_out   = is_dma && !off_q;
    assign exp_dma_ack_out    = is_dma ? chan_q : '0;
    assign offboard_owner_out = is_dma && off_q;
    assign cpu16_irq_out      = any_irq && grant_cpu16_out;

    // -------------------------------------------------------------------
    // Control merge and address
    // -------------------------------------------------------------------
    wire own_rd = grant_cpu16_out ? c16_rd : grant_cpu8_out ? c8_rd : d_rd;
    wire own_wr = grant_cpu16_out ? c16_wr : grant_cpu8_out ? c8_wr : d_wr;
    wire own_io = grant_cpu16_out ? c16_io : grant_cpu8_out ? c8_io : d_io;
    wire io_bar = own_io && (grant_cpu8_out || offboard_owner_out);
    wire pass   = (own_rd | own_wr) && !io_bar;
    wire [dcba_pkg::FULL_AW-1:0] own_a =
        grant_cpu16_out ? c16_a :
        grant_cpu8_out  ? {bank_cpu8_q, c8_a} : {bank_dma_q, d_a};
    wire slow_hit = own_io && ((own_a[15:8] & dcba_pkg::SLOW_IO_MASK) == dcba_pkg::SLOW_IO_PAGE);

    logic                         emcs_q;
    logic                         rd_q;
    logic                         wr_q;
    logic                         io_q;
    logic                         refused_q;
    logic [dcba_pkg::FULL_AW-1:0] addr_q;
    logic [7:0]                   wait_q;

    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            emcs_q    <= 1'b0;
            rd_q      <= 1'b0;
            wr_q      <= 1'b0;
            io_q      <= 1'b0;
            refused_q <= 1'b0;
            addr_q    <= '0;
        end else begin
            emcs_q    <= pass && !own_io;
            rd_q      <= own_rd && pass && (own_io || emcs_q);
            wr_q      <= own_wr && pass && (own_io || emcs_q);
            io_q      <= own_io && pass;
            refused_q <= (own_rd | own_wr) && io_bar;
            addr_q    <= own_a;
        end
    end

    assign early_memory_cycle_start_out = emcs_q;
    assign bus_rd_out     = rd_q;
    assign bus_wr_out     = wr_q;
    assign bus_io_out     = io_q;
    assign bus_addr_out   = addr_q;
    assign io_refused_out = refused_q;

    // -------------------------------------------------------------------
    // Wait states
    // -------------------------------------------------------------------
    wire slow_start = pass && slow_hit && !io_q && !grant_cpu8_out;
    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            wait_q <= '0;
        end else if (slow_start) begin
            wait_q <= 8'(WAIT_N);
        end else if (wait_q != '0) begin
            wait_q <= wait_q - 1'b1;
        end
    end
    assign ready_out = (wait_q == '0);

    // -------------------------------------------------------------------
    // Data path
    // -------------------------------------------------------------------
    logic [dcba_pkg::MAIN_DW-1:0] mdo_q;
    logic [dcba_pkg::EXP_DW-1:0]  xdo_q;
    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            mdo_q <= '0;
            xdo_q <= '0;
        end else begin
            mdo_q <= xdat_s[dcba_pkg::MAIN_DW-1:0];
            xdo_q <= {{(dcba_pkg::EXP_DW - dcba_pkg::MAIN_DW){1'b0}}, mdat_s};
        end
    end
    assign main_data_out = mdo_q;
    assign exp_data_out  = xdo_q;
endmodule : dcba_arbiter

`default_nettype wire

// ---- bench/dcba_arbiter_chk.sv ----
// Port-level checks for the dual-processor bus arbiter.
// Assumes it is bound into dcba_arbiter; one clock domain.
`default_nettype none
module dcba_arbiter_chk #(
    parameter int unsigned WAIT_N = 8
) (
    input wire logic        core_clk_in,
    input wire logic        sys_rst_in,
    input wire logic        int_req_in,
    input wire logic        grant_cpu16_out,
    input wire logic        grant_cpu8_out,
    input wire logic        dma_hold_ack_out,
    input wire logic [3:0]  exp_dma_ack_out,
    input wire logic        offboard_owner_out,
    input wire logic [19:0] bus_addr_out,
    input wire logic        bus_rd_out,
    input wire logic        bus_wr_out,
    input wire logic        bus_io_out,
    input wire logic        early_memory_cycle_start_out,
    input wire logic        ready_out
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge core_clk_in);
    endclocking
    default disable iff (sys_rst_in);
    int unsigned low_cnt;
    logic        prev8_q;
    // Wait length and last processor owner
    always_ff @(posedge core_clk_in) begin
        low_cnt <= (sys_rst_in || ready_out) ? 0 : low_cnt + 1;
        prev8_q <= sys_rst_in ? 1'b0 : (grant_cpu16_out || grant_cpu8_out) ? grant_cpu8_out : prev8_q;
    end
    a_single_owner: assert property ($onehot({grant_cpu16_out, grant_cpu8_out, dma_hold_ack_out, offboard_owner_out}))
        else $error("bus owner not unique");
    a_chan_ack: assert property ($onehot0(exp_dma_ack_out) && offboard_owner_out == (exp_dma_ack_out != 4'h0))
        else $error("channel ack disagrees with owner");
    a_early_start: assert property ($rose(bus_rd_out || bus_wr_out) && !bus_io_out |-> $past(early_memory_cycle_start_out))
        else $error("memory strobe without early start");
    a_byte_no_io: assert property (grant_cpu8_out |-> !(bus_io_out && (bus_rd_out || bus_wr_out)))
        else $error("io strobe under byte processor");
    a_board_no_io: assert property (offboard_owner_out |-> !(bus_io_out && (bus_rd_out || bus_wr_out)))
        else $error("io strobe under off-board master");
    a_wait_start: assert property ($rose(bus_io_out) && bus_addr_out[15:8] == 8'h00 |-> !ready_out)
        else $error("slow io without wait");
    a_wait_len: assert property ($rose(ready_out) |-> low_cnt == WAIT_N)
        else $error("wait length wrong");
    a_cycle_edge: assert property ($fell(grant_cpu16_out) |-> !bus_rd_out && !bus_wr_out)
        else $error("owner changed inside a cycle");
    a_dma_return: assert property ($fell(dma_hold_ack_out) || $fell(offboard_owner_out) |->
        (prev8_q ? grant_cpu8_out : grant_cpu16_out))
        else $error("bus not returned to previous owner");
    a_irq_swap: assert property ($rose(int_req_in) && grant_cpu8_out |-> ##[1:40] grant_cpu16_out)
        else $error("interrupt did not switch owner");
    c_handover: cover property ($rose(grant_cpu8_out));
    c_offboard: cover property ($rose(offboard_owner_out));
    c_waits: cover property ($fell(ready_out));
endmodule : dcba_arbiter_chk
`default_nettype wire

// ---- bench/dcba_owner_model.sv ----
// Behavioural bus owner: processor, DMA controller or off-board master.
// Assumes one go pulse per cycle; drives just after the rising edge.
`default_nettype none
module dcba_owner_model #(
    parameter int unsigned AW  = 16,
    parameter int unsigned LEN = 6
) (
    input wire logic          clk_in,
    input wire logic          rst_in,
    input wire logic          go_in,
    input wire logic          wr_in,
    input wire logic          io_in,
    input wire logic [AW-1:0] addr_in,
    input wire logic          ready_in,
    output logic              rd_out,
    output logic              wr_out,
    output logic              io_out,
    output logic [AW-1:0]     addr_out,
    output logic              busy_out
);
    timeunit 1ns;
    timeprecision 1ps;
    int unsigned cnt_q;
    always @(posedge clk_in) begin
        if (rst_in) begin
            {rd_out, wr_out, io_out, busy_out} <= 4'h0;
            addr_out <= '0;
            cnt_q <= 0;
        end else if (go_in && !busy_out) begin
            {rd_out, wr_out, io_out, busy_out} <= {!wr_in, wr_in, io_in, 1'b1};
            addr_out <= addr_in;
            cnt_q <= LEN;
        end else if (busy_out && ready_in && cnt_q > 1) begin
            cnt_q <= cnt_q - 1;
        end else if (busy_out && ready_in) begin
            {rd_out, wr_out, io_out, busy_out} <= 4'h0;
            addr_out <= ~addr_out;
        end
    end
endmodule : dcba_owner_model
`default_nettype wire

// ---- bench/dual_cpu_bus_arbiter_bench.sv ----
// Self-checking bench for the dual-processor bus arbiter.
// Assumes the owner model and checker files are compiled first.
`default_nettype none
module dual_cpu_bus_arbiter_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk_in = 1'b0, sys_rst_in = 1'b1, xtal_ref_in = 1'b0, dma_hold_req_in = 1'b0;
    logic int_req_in = 1'b0, bank_load_in = 1'b0, bank_target_in = 1'b0, c_wr = 1'b0, c_io = 1'b0;
    logic cpu16_rd_in, cpu16_wr_in, cpu16_io_in, cpu8_rd_in, cpu8_wr_in, cpu8_io_in, dma_rd_in, dma_wr_in, dma_io_in;
    logic grant_cpu16_out, grant_cpu8_out, dma_hold_ack_out, offboard_owner_out, cpu16_irq_out, bus_rd_out;
    logic bus_wr_out, bus_io_out, early_memory_cycle_start_out, io_refused_out, ready_out;
    logic clk_cpu16_out, clk_cpu8_out, clk_dma_out;
    logic [2:0]  go = 3'h0;
    wire logic [2:0] busy;
    logic [3:0]  exp_dma_req_in = 4'h0, bank_value_in = 4'h0, exp_dma_ack_out, bank8, bankd;
    logic [6:0]  exp_irq_in = 7'h00;
    logic [7:0]  main_data_in = 8'h00, main_data_out;
    logic [15:0] exp_data_in = 16'h0000, exp_data_out, cpu8_addr_in, dma_addr_in;
    logic [19:0] cpu16_addr_in, bus_addr_out, c_addr = 20'h00000;
    int          error_cnt = 0, n_tests = 0, cyc_cnt = 0;
    wire logic [3:0] owners = {offboard_owner_out, dma_hold_ack_out, grant_cpu8_out, grant_cpu16_out};

    dcba_arbiter #(.WAIT_N(8)) dut_u (.*);
    dcba_owner_model #(.AW(20)) cpu16_u (.clk_in(core_clk_in), .rst_in(sys_rst_in), .go_in(go[0]), .wr_in(c_wr),
        .io_in(c_io), .addr_in(c_addr), .ready_in(ready_out), .rd_out(cpu16_rd_in), .wr_out(cpu16_wr_in),
        .io_out(cpu16_io_in), .addr_out(cpu16_addr_in), .busy_out(busy[0]));
    dcba_owner_model #(.AW(16)) cpu8_u (.clk_in(core_clk_in), .rst_in(sys_rst_in), .go_in(go[1]), .wr_in(c_wr),
        .io_in(c_io), .addr_in(c_addr[15:0]), .ready_in(ready_out), .rd_out(cpu8_rd_in), .wr_out(cpu8_wr_in),
        .io_out(cpu8_io_in), .addr_out(cpu8_addr_in), .busy_out(busy[1]));
    dcba_owner_model #(.AW(16)) dma_u (.clk_in(core_clk_in), .rst_in(sys_rst_in), .go_in(go[2]), .wr_in(c_wr),
        .io_in(c_io), .addr_in(c_addr[15:0]), .ready_in(ready_out), .rd_out(dma_rd_in), .wr_out(dma_wr_in),
        .io_out(dma_io_in), .addr_out(dma_addr_in), .busy_out(busy[2]));

    always #2 core_clk_in = ~core_clk_in;
    always #20.833 xtal_ref_in = ~xtal_ref_in;
    always @(posedge core_clk_in) begin
        cyc_cnt++;
        if (cyc_cnt == 20000) begin
            error_cnt++;
            summarize();
        end
    end

    task automatic check(input logic [19:0] seen, input logic [19:0] exp);
        n_tests++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR time %0t seen %0h expected %0h", $time, seen, exp);
        end
    endtask : check

    task automatic summarize();
        $display("Checks %0d, mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : summarize

    task automatic wait_own(input int k);
        for (int n = 0; n < 60 && owners[k] !== 1'b1; n++) begin
            @(negedge core_clk_in);
        end
        check(owners[k], 1'b1);
    endtask : wait_own

    task automatic load(input logic tgt, input logic [3:0] v);
        {bank_target_in, bank_value_in} = {tgt, v};
        bank_load_in = 1'b1;
        @(negedge core_clk_in);
        bank_load_in = 1'b0;
    endtask : load

    task automatic cyc(input int who, input logic wr, io, input logic [19:0] a, input logic pass,
                       input logic [19:0] ea);
        logic [19:0] got;
        logic        seen_s, seen_r;
        {seen_s, seen_r, got} = {2'b00, ~ea};
        {c_wr, c_io, c_addr} = {wr, io, a};
        go[who] = 1'b1;
        @(negedge core_clk_in);
        go[who] = 1'b0;
        for (int k = 0; k < 80 && (k < 10 || busy[who] || bus_rd_out || bus_wr_out); k++) begin
            @(negedge core_clk_in);
            if (!seen_s && (bus_rd_out || bus_wr_out)) got = bus_addr_out;
            seen_s |= bus_rd_out | bus_wr_out;
            seen_r |= io_refused_out;
        end
        check(seen_s, pass);
        check(pass ? got : {19'h0, seen_r}, pass ? ea : 20'h00001);
    endtask : cyc

    initial begin
        logic [19:0] a;
        int          c16 = 0, c8 = 0, cd = 0;
        logic        p16 = 1'b0, p8 = 1'b0, pd = 1'b0;
        void'($urandom(11));
        repeat (4) @(negedge core_clk_in);
        sys_rst_in = 1'b0;
        repeat (3) @(negedge core_clk_in);
        check(owners, 4'h1);
        check(ready_out, 1'b1);
        a = 20'($urandom());
        {bank8, bankd} = 8'($urandom());
        cyc(0, 1'b0, 1'b0, a, 1'b1, a);
        load(dcba_pkg::BANK_TGT_CPU8, bank8);
        load(dcba_pkg::BANK_TGT_DMA, bankd);
        dma_hold_req_in = 1'b1;
        wait_own(2);
        check(owners, 4'h4);
        cyc(2, 1'b1, 1'b0, a, 1'b1, {bankd, a[15:0]});
        cyc(2, 1'b0, 1'b1, {12'h000, a[7:0]}, 1'b1, {bankd, 8'h00, a[7:0]});
        dma_hold_req_in = 1'b0;
        wait_own(0);
        cyc(0, 1'b1, 1'b1, 20'(dcba_pkg::HANDOVER_PORT), 1'b1, 20'(dcba_pkg::HANDOVER_PORT));
        wait_own(1);
        cyc(1, 1'b0, 1'b0, ~a, 1'b1, {bank8, ~a[15:0]});
        exp_dma_req_in = 4'hA;
        wait_own(3);
        check(exp_dma_ack_out, 4'h2);
        cyc(2, 1'b0, 1'b1, a, 1'b0, a);
        cyc(2, 1'b0, 1'b0, a, 1'b1, {bankd, a[15:0]});
        exp_dma_req_in = 4'h0;
        wait_own(1);
        cyc(1, 1'b1, 1'b1, a, 1'b0, a);
        wait_own(0);
        cyc(0, 1'b1, 1'b1, 20'(dcba_pkg::HANDOVER_PORT), 1'b1, 20'(dcba_pkg::HANDOVER_PORT));
        wait_own(1);
        int_req_in = 1'b1;
        wait_own(0);
        check(cpu16_irq_out, 1'b1);
        int_req_in = 1'b0;
        repeat (4) @(negedge core_clk_in);
        check(cpu16_irq_out, 1'b0);
        exp_irq_in = 7'($urandom_range(127, 1));
        repeat (4) @(negedge core_clk_in);
        check(cpu16_irq_out, 1'b1);
        exp_irq_in = 7'h00;
        for (int i = 0; i < 4; i++) begin
            {exp_data_in, main_data_in} = 24'($urandom());
            repeat (5) @(negedge core_clk_in);
            check(main_data_out, exp_data_in[7:0]);
            check(exp_data_out, {8'h00, main_data_in});
        end
        repeat (3000) begin
            @(negedge core_clk_in);
            c16 += int'(clk_cpu16_out && !p16);
            c8 += int'(clk_cpu8_out && !p8);
            cd += int'(clk_dma_out && !pd);
            {p16, p8, pd} = {clk_cpu16_out, clk_cpu8_out, clk_dma_out};
        end
        check(c16 inside {[12 * dcba_pkg::CPU16_MHZ - 1 : 12 * dcba_pkg::CPU16_MHZ + 1]}, 1'b1);
        check(c8 inside {[12 * dcba_pkg::CPU8_MHZ - 1 : 12 * dcba_pkg::CPU8_MHZ + 1]}, 1'b1);
        check(cd inside {[12 * dcba_pkg::DMA_MHZ - 1 : 12 * dcba_pkg::DMA_MHZ + 1]}, 1'b1);
        summarize();
    end
endmodule : dual_cpu_bus_arbiter_bench

bind dcba_arbiter dcba_arbiter_chk #(.WAIT_N(WAIT_N)) chk_u (.core_clk_in, .sys_rst_in, .int_req_in, .grant_cpu16_out,
    .grant_cpu8_out, .dma_hold_ack_out, .exp_dma_ack_out, .offboard_owner_out, .bus_addr_out, .bus_rd_out, .bus_wr_out,
    .bus_io_out, .early_memory_cycle_start_out, .ready_out);
`default_nettype wire
